// File: hw/cmd_decoder.sv
// Purpose: serial host command decoder for reset, activate, slot and config bytes
// Assumes: byte-framed serial link, pins synchronised here to clk_i
// Notes:   one byte per chip-select low period; channel enables held externally
`timescale 1ns/10ps
module cmd_decoder
    import cmd_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    input  wire logic                 sel_n_i,
    input  wire logic                 dclk_i,
    input  wire logic                 dio_i,
    input  wire logic                 frame_sync_pulse_i,
    input  wire logic                 chop_ref_i,
    input  wire logic [cmd_pkg::NCH-1:0] ch_enable_i,
    output logic                      dio_o,
    output logic                      dio_oe_o,
    output logic [cmd_pkg::NCH-1:0]   channel_active_status_o,
    output logic [cmd_pkg::NCH-1:0]   pcm_tx_valid_o,
    output logic [cmd_pkg::NCH-1:0]   tx_hwy_a_en_o,
    output logic [cmd_pkg::NCH-1:0]   tx_hwy_b_en_o,
    output logic [cmd_pkg::NCH-1:0]   rx_hwy_b_sel_o,
    output logic [cmd_pkg::NCH*7-1:0] tx_time_slot_o,
    output logic [cmd_pkg::NCH*7-1:0] rx_time_slot_o,
    output logic                      tx_clock_edge_o,
    output logic [2:0]                rx_clock_slot_o,
    output logic [2:0]                tx_clock_slot_o,
    output logic                      irq_output_style_o,
    output logic                      chopper_clk_o,
    output logic                      pcm_signaling_on_o,
    output logic                      master_clock_source_o,
    output logic                      e1_mux_allowed_o,
    output logic [15:0]               master_freq_khz_o,
    output logic                      freq_reserved_o,
    output logic                      internal_reset_o
);
    import cmd_pkg::*;

    // pin synchronisers: two flops each, first read only by second
    logic [4:0] sy1_q, sy2_q;
    logic       dclk_prev_q, sel_prev_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            // pin idle levels, so no false edge follows reset
            sy1_q <= 5'h18;
            sy2_q <= 5'h18;
        end else begin
            sy1_q <= {sel_n_i, dclk_i, dio_i, frame_sync_pulse_i, chop_ref_i};
            sy2_q <= sy1_q;
        end
    end
    wire sel_n_s = sy2_q[4];
    wire dclk_s  = sy2_q[3];
    wire dio_s   = sy2_q[2];
    wire fsync_s = sy2_q[1];
    wire chop_s  = sy2_q[0];

    // command reset acts like the pin on registers: a soft reset flop clears registers, activation and divider next cycle, not the shifter
    logic soft_rst_q;                                        
    wire  rst_all  = soft_rst_q;

    logic       fsync_prev_q, chop_prev_q;
    wire dclk_rise = dclk_s & ~dclk_prev_q;
    wire dclk_fall = ~dclk_s & dclk_prev_q;
    wire sel_start = ~sel_n_s & sel_prev_q;
    wire sel_end   = sel_n_s & ~sel_prev_q;
    wire fsync_rise = fsync_s & ~fsync_prev_q;
    wire chop_rise = chop_s & ~chop_prev_q;

    // byte shifter; only the last 8 rising edges of a frame count
    logic [7:0] sh_q;
    logic [4:0] nbits_q;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dclk_prev_q <= 1'b1;
            sel_prev_q  <= 1'b1;
            fsync_prev_q <= 1'b0;
            chop_prev_q <= 1'b0;
            sh_q        <= 8'h00;
            nbits_q     <= 5'h00;
        end else begin
            dclk_prev_q <= dclk_s;
            sel_prev_q  <= sel_n_s;
            fsync_prev_q <= fsync_s;
            chop_prev_q <= chop_s;
            if (sel_start)
                nbits_q <= 5'h00;
            else if (!sel_n_s && dclk_rise) begin
                sh_q <= {sh_q[6:0], dio_s};
                if (nbits_q != 5'h1F)
                    nbits_q <= nbits_q + 5'h01;
            end
        end
    end
    wire byte_ok   = sel_end && nbits_q >= 5'h08 && nbits_q < 5'h10;
    wire long_rst  = sel_end && nbits_q >= 5'h10;

    // register file
    cmd_state_t  st_q;
    logic [6:0]  op_q;
    logic [7:0]  tx_reg_q [NCH];
    logic [7:0]  rx_reg_q [NCH];
    logic [7:0]  cslot_q, cfg_q, rd_q;
    logic [NCH-1:0] act_q;
    logic [1:0]  fcnt_q [NCH];
    wire any_en  = |ch_enable_i;

    function automatic int first_en(input logic [NCH-1:0] en);
        first_en = 0;
        for (int i = NCH - 1; i >= 0; i--)
            if (en[i]) first_en = i;
    endfunction

    wire [1:0] fe   = 2'(first_en(ch_enable_i));
    wire is_cmd     = st_q == CMD_ST_CMD && byte_ok;
    wire is_wr      = st_q == CMD_ST_WR && byte_ok;
    wire glob_ok    = sh_q[7:1] == CMD_CONFIG
                    || (sh_q[7:1] == CMD_CLK_SLOT && any_en);
    wire chan_cmd   = sh_q[7:1] == CMD_TX_SLOT || sh_q[7:1] == CMD_RX_SLOT;
    wire data_cmd   = (chan_cmd && any_en) || glob_ok;
    wire [7:0] rd_sel = op_q == CMD_TX_SLOT ? tx_reg_q[fe] :
                        op_q == CMD_RX_SLOT ? rx_reg_q[fe] :
                        op_q == CMD_CLK_SLOT ? cslot_q : cfg_q;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i)
            soft_rst_q <= 1'b0;
        else
            soft_rst_q <= (is_cmd && sh_q == CMD_HW_RESET) || long_rst;
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q    <= CMD_ST_CMD;
            op_q    <= 7'h00;
            cslot_q <= CLK_SLOT_RST;
            cfg_q   <= CONFIG_RST;
            rd_q    <= 8'h00;
        end else if (rst_all) begin
            st_q    <= CMD_ST_CMD;
            op_q    <= 7'h00;
            cslot_q <= CLK_SLOT_RST;
            cfg_q   <= CONFIG_RST;
            rd_q    <= 8'h00;
        end else begin
            unique case (st_q)
                CMD_ST_CMD: if (byte_ok && data_cmd) begin
                    op_q <= sh_q[7:1];
                    if (sh_q[0]) begin
                        st_q <= CMD_ST_RD;
                        rd_q <= 8'h00;
                    end else
                        st_q <= CMD_ST_WR;
                end
                CMD_ST_WR: if (byte_ok) begin
                    if (op_q == CMD_CLK_SLOT) cslot_q <= sh_q;
                    if (op_q == CMD_CONFIG)   cfg_q   <= sh_q;
                    st_q <= CMD_ST_CMD;
                end
                CMD_ST_RD: begin
                    if (sel_start) rd_q <= rd_sel;
                    else if (!sel_n_s && dclk_fall) rd_q <= {rd_q[6:0], 1'b0};
                    if (sel_end && nbits_q >= 5'h08) st_q <= CMD_ST_CMD;
                end
                default: st_q <= CMD_ST_CMD;
            endcase
        end
    end

    // per-channel registers and activation
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            always_ff @(posedge clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    tx_reg_q[g] <= 8'(g);
                    rx_reg_q[g] <= 8'(g);
                    act_q[g]    <= 1'b0;
                    fcnt_q[g]   <= 2'h0;
                end else if (rst_all) begin
                    tx_reg_q[g] <= 8'(g);
                    rx_reg_q[g] <= 8'(g);
                    act_q[g]    <= 1'b0;
                    fcnt_q[g]   <= 2'h0;
                end else begin
                    if (is_wr && ch_enable_i[g] && op_q == CMD_TX_SLOT)
                        tx_reg_q[g] <= sh_q;
                    if (is_wr && ch_enable_i[g] && op_q == CMD_RX_SLOT)
                        rx_reg_q[g] <= sh_q;
                    if (is_cmd && sh_q == CMD_ACTIVATE && ch_enable_i[g]) begin
                        act_q[g]  <= 1'b1;
                        fcnt_q[g] <= 2'h0;
                    end else if (act_q[g] && fsync_rise && fcnt_q[g] != FRAMES_WAIT)
                        fcnt_q[g] <= fcnt_q[g] + 2'h1;
                end
            end
        end
    endgenerate

    // chopper divider from 2048 kHz reference
    logic [2:0] chop_cnt_q;
    logic       chop_q;
    wire  [2:0] chop_top = cfg_q[CHOP_BIT] ? CHOP_DIV_B : CHOP_DIV_A;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            chop_cnt_q <= 3'h0;
            chop_q     <= 1'b0;
        end else if (rst_all) begin
            // command reset restarts the divider just as the pin does
            chop_cnt_q <= 3'h0;
            chop_q     <= 1'b0;
        end else if (chop_rise) begin
            chop_cnt_q <= chop_cnt_q >= chop_top ? 3'h0 : chop_cnt_q + 3'h1;
            chop_q     <= chop_cnt_q < {1'b0, chop_top[2:1]} + 3'h1;
        end
    end

    // frequency decode, global
    wire [15:0] base = cfg_q[1:0] == 2'h0 ? FREQ_1536 :
                       cfg_q[1:0] == 2'h1 ? FREQ_1544 : FREQ_2048;
    wire [15:0] freq = base << cfg_q[3:2];
    wire        frsv = cfg_q[1:0] == 2'h3 || cfg_q[3:2] == 2'h3;

    // output flops
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dio_o <= 1'b0; dio_oe_o <= 1'b0;
            channel_active_status_o <= '0; pcm_tx_valid_o <= '0;
            tx_hwy_a_en_o <= '0; tx_hwy_b_en_o <= '0; rx_hwy_b_sel_o <= '0;
            tx_time_slot_o <= '0; rx_time_slot_o <= '0;
            tx_clock_edge_o <= 1'b0; rx_clock_slot_o <= 3'h0; tx_clock_slot_o <= 3'h0;
            irq_output_style_o <= 1'b0; chopper_clk_o <= 1'b0;
            pcm_signaling_on_o <= 1'b0; master_clock_source_o <= 1'b0;
            e1_mux_allowed_o <= 1'b0; master_freq_khz_o <= 16'h0000;
            freq_reserved_o <= 1'b0; internal_reset_o <= 1'b0;
        end else begin
            dio_o    <= rd_q[7];
            dio_oe_o <= st_q == CMD_ST_RD && !sel_n_s;
            channel_active_status_o <= act_q;
            for (int i = 0; i < NCH; i++) begin
                pcm_tx_valid_o[i] <= act_q[i] && fcnt_q[i] == FRAMES_WAIT;
                tx_hwy_a_en_o[i]  <= cslot_q[BOTH_HWY_BIT] || !tx_reg_q[i][HWY_BIT];
                tx_hwy_b_en_o[i]  <= cslot_q[BOTH_HWY_BIT] || tx_reg_q[i][HWY_BIT];
                rx_hwy_b_sel_o[i] <= rx_reg_q[i][HWY_BIT];
                tx_time_slot_o[i*7 +: 7] <= tx_reg_q[i][6:0];
                rx_time_slot_o[i*7 +: 7] <= rx_reg_q[i][6:0];
            end
            tx_clock_edge_o       <= cslot_q[TX_EDGE_BIT];
            rx_clock_slot_o       <= cslot_q[RX_CSLOT_LSB +: 3];
            tx_clock_slot_o       <= cslot_q[TX_CSLOT_LSB +: 3];
            irq_output_style_o    <= cfg_q[IRQ_STY_BIT];
            chopper_clk_o         <= chop_q;
            pcm_signaling_on_o    <= cfg_q[SIG_BIT];
            master_clock_source_o <= cfg_q[CLKSRC_BIT];
            e1_mux_allowed_o      <= cfg_q[CLKSRC_BIT];
            master_freq_khz_o     <= freq;
            freq_reserved_o       <= frsv;
            internal_reset_o      <= rst_all;
        end
    end

    property p_cfg_reset;
        @(posedge clk_i) disable iff (!nrst_i) $rose(soft_rst_q) |=> cfg_q == CONFIG_RST && cslot_q == 8'h00;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("config not reset");
    property p_act;
        @(posedge clk_i) disable iff (!nrst_i)
            is_cmd && sh_q == CMD_ACTIVATE && ch_enable_i[0] && !rst_all |=> act_q[0] ##1 !pcm_tx_valid_o[0];
    endproperty
    a_act: assert property (p_act) else $error("activate wrong");
    property p_glob;
        @(posedge clk_i) disable iff (!nrst_i)
            is_cmd && sh_q[7:1] == CMD_CLK_SLOT && !any_en |=> st_q == CMD_ST_CMD;
    endproperty
    a_glob: assert property (p_glob) else $error("clock slot accessed unenabled");
    property p_both;
        @(posedge clk_i) disable iff (!nrst_i) cslot_q[BOTH_HWY_BIT] |-> ##1 tx_hwy_a_en_o[1] && tx_hwy_b_en_o[1];
    endproperty
    a_both: assert property (p_both) else $error("both highways off");
    property p_nop;
        @(posedge clk_i) disable iff (!nrst_i)
            is_cmd && sh_q == CMD_NOP && !rst_all |=> $stable(cfg_q) && $stable(cslot_q) && $stable(act_q)
                && $stable(tx_reg_q[0]) && st_q == CMD_ST_CMD;
    endproperty
    a_nop: assert property (p_nop) else $error("nop changed state");
    property p_slot_rst;
        @(posedge clk_i) disable iff (!nrst_i)
            $rose(soft_rst_q) |=> tx_reg_q[0] == 8'h00 && rx_reg_q[3] == 8'h03 && act_q == '0;
    endproperty
    a_slot_rst: assert property (p_slot_rst) else $error("slots not reset");
    property p_txv_wait;
        @(posedge clk_i) disable iff (!nrst_i)
            $rose(act_q[2]) |=> !pcm_tx_valid_o[2] ##1 !pcm_tx_valid_o[2];
    endproperty
    a_txv_wait: assert property (p_txv_wait) else $error("valid too early after activate");
endmodule

// File: hw/cmd_pkg.sv
// Purpose: constants for the serial command decoder of a four-channel codec
// Assumes: 100 MHz system clock, 2.048 MHz chopper reference from outside
// Notes:   command codes, field positions and reset values
package cmd_pkg;
    localparam int          NCH          = 4;
    localparam logic [7:0]  CMD_HW_RESET = 8'h04;
    localparam logic [7:0]  CMD_NOP      = 8'h06;
    localparam logic [7:0]  CMD_ACTIVATE = 8'h0E;
    localparam logic [6:0]  CMD_TX_SLOT  = 7'h20;  // 40h/41h, bit 0 is read
    localparam logic [6:0]  CMD_RX_SLOT  = 7'h21;  // 42h/43h
    localparam logic [6:0]  CMD_CLK_SLOT = 7'h22;  // 44h/45h
    localparam logic [6:0]  CMD_CONFIG   = 7'h23;  // 46h/47h
    localparam logic [7:0]  CLK_SLOT_RST = 8'h00;
    localparam logic [7:0]  CONFIG_RST   = 8'h9A;
    localparam logic [3:0]  CH_EN_RST    = 4'hF;
    localparam int          HWY_BIT      = 7;
    localparam int          BOTH_HWY_BIT = 7;
    localparam int          TX_EDGE_BIT  = 6;
    localparam int          RX_CSLOT_LSB = 3;
    localparam int          TX_CSLOT_LSB = 0;
    localparam int          IRQ_STY_BIT  = 7;
    localparam int          CHOP_BIT     = 6;
    localparam int          SIG_BIT      = 5;
    localparam int          CLKSRC_BIT   = 4;
    localparam logic [2:0]  CHOP_DIV_A   = 3'h7;   // divide by 8, count 0..7
    localparam logic [2:0]  CHOP_DIV_B   = 3'h6;   // divide by 7, count 0..6
    localparam logic [1:0]  FRAMES_WAIT  = 2'h2;
    localparam logic [2:0]  BITS_LAST    = 3'h7;
    localparam logic [15:0] FREQ_1536    = 16'h0600; // kHz
    localparam logic [15:0] FREQ_1544    = 16'h0608;
    localparam logic [15:0] FREQ_2048    = 16'h0800;
    typedef enum logic [2:0] {
        CMD_ST_CMD  = 3'b001,
        CMD_ST_WR   = 3'b010,
        CMD_ST_RD   = 3'b100
    } cmd_state_t;
endpackage

// File: sim/cmd_decoder_bench.sv
// Purpose: self-checking bench for the serial command decoder
// Assumes: 100 MHz clock, chopper reference near 2.048 MHz
// Notes:   host model issues all frames; enables driven here
`timescale 1ns/10ps
module cmd_decoder_bench;
    import cmd_pkg::*;
    logic clk_i = 1'b0, nrst_i = 1'b0, fsync = 1'b0, cref = 1'b0;
    logic sel_n, dclk, dio, dev_dio, dev_oe;
    logic [3:0] en = 4'hF, act, txv, aen, ben, rxb;
    logic [27:0] txs, rxs;
    logic edge_o, irq, chop, sig, src, e1, resv, ires;
    logic [2:0] rx_cslot, tx_cslot;
    logic [15:0] freq;
    logic [7:0] r;
    int failures = 0, total_checks = 0, cycles = 0, ref_n = 0, chop_per = 0, oe_n = 0, ires_n = 0;
    // released data line rests at its pull-up
    wire dio_line = dev_oe ? dev_dio : 1'b1;
    localparam logic [27:0] SLOT_RST = {7'h03, 7'h02, 7'h01, 7'h00};

    always #5 clk_i = ~clk_i;
    always #244 cref = ~cref;
    always @(posedge cref) ref_n++;
    always @(posedge chop) begin
        chop_per = ref_n;
        ref_n = 0;
    end

    cmd_host_model i_cmd_host_model (.clk_i(clk_i), .dev_dio_i(dio_line), .sel_n_o(sel_n),
        .dclk_o(dclk), .dio_o(dio));
    cmd_decoder i_cmd_decoder (.clk_i(clk_i), .nrst_i(nrst_i), .sel_n_i(sel_n), .dclk_i(dclk),
        .dio_i(dio), .frame_sync_pulse_i(fsync), .chop_ref_i(cref), .ch_enable_i(en),
        .dio_o(dev_dio), .dio_oe_o(dev_oe), .channel_active_status_o(act), .pcm_tx_valid_o(txv),
        .tx_hwy_a_en_o(aen), .tx_hwy_b_en_o(ben), .rx_hwy_b_sel_o(rxb), .tx_time_slot_o(txs),
        .rx_time_slot_o(rxs), .tx_clock_edge_o(edge_o), .rx_clock_slot_o(rx_cslot),
        .tx_clock_slot_o(tx_cslot), .irq_output_style_o(irq), .chopper_clk_o(chop),
        .pcm_signaling_on_o(sig), .master_clock_source_o(src), .e1_mux_allowed_o(e1),
        .master_freq_khz_o(freq), .freq_reserved_o(resv), .internal_reset_o(ires));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %0h seen %0h", n, e, s);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        i_cmd_host_model.xfer({8'h00, c}, 8, r);
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        cmd(c);
        cmd(d);
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] e, input string n);
        int n0;
        n0 = oe_n;
        cmd(c);
        cmd(8'h00);
        chk(n, r, e);
        chk("dio_oe", oe_n - n0 > 60, 1);
        chk("dio_oe_idle", dev_oe, 0);
    endtask
    task automatic fsync_pulse();
        fsync = 1'b1;
        i_cmd_host_model.wait_clk(4);
        fsync = 1'b0;
        i_cmd_host_model.wait_clk(20);
    endtask
    task automatic defaults();
        chk("txslot", txs, SLOT_RST);
        chk("rxslot", {rxb, rxs}, {4'h0, SLOT_RST});
        chk("clkslot", {edge_o, rx_cslot, tx_cslot, ben}, 0);
        chk("hwy_a", aen, 4'hF);
        chk("cfg", {irq, chop_per == 8, sig, src, e1, freq, resv}, {5'b11011, 16'd8192, 1'b0});
        chk("idle", {act, txv}, 0);
    endtask
    task automatic give_verdict();
        if (failures == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk_i) begin
        if (dev_oe)
            oe_n++;
        if (ires)
            ires_n++;
        cycles++;
        if (cycles == 40000) begin
            failures++;
            give_verdict();
        end
    end

    initial begin
        repeat (5) @(posedge clk_i);
        #1 nrst_i = 1'b1;
        i_cmd_host_model.wait_clk(1000);
        defaults();
        rd(8'h47, CONFIG_RST, "cfg_rd");
        rd(8'h41, 8'h00, "tx_rd");
        en = 4'b0110;
        wr(8'h40, 8'hA5);
        chk("txslot", txs, {7'h03, 7'h25, 7'h25, 7'h00});
        chk("hwy", {aen, ben}, 8'h96);
        rd(8'h41, 8'hA5, "tx_rd");
        en = 4'b1000;
        wr(8'h42, 8'h85);
        chk("rxslot", {rxb, rxs}, {4'b1000, 7'h05, 7'h02, 7'h01, 7'h00});
        rd(8'h43, 8'h85, "rx_rd");
        en = 4'hF;
        cmd(CMD_NOP);
        chk("nop_tx", txs, {7'h03, 7'h25, 7'h25, 7'h00});
        chk("nop_rx", rxs, {7'h05, 7'h02, 7'h01, 7'h00});
        chk("nop_cfg", {irq, src, act}, 6'b110000);
        en = 4'h0;
        wr(8'h44, 8'hD5);
        chk("clk_off", {edge_o, rx_cslot, tx_cslot}, 0);
        en = 4'b0100;
        wr(8'h44, 8'hD5);
        chk("clk_on", {edge_o, rx_cslot, tx_cslot}, {1'b1, 3'd2, 3'd5});
        chk("both", {aen, ben}, 8'hFF);
        rd(8'h45, 8'hD5, "clk_rd");
        en = 4'h0;
        cmd(8'h45);
        cmd(8'h00);
        chk("clk_rd_off", r, 8'hFF);
        for (int c = 0; c < 16; c++) begin
            wr(8'h46, {4'h6, c[3:0]});
            chk("resv", resv, c[1:0] == 2'd3 || c[3:2] == 2'd3);
            if (c[1:0] != 2'd3 && c[3:2] != 2'd3)
                chk("freq", freq, (c[1:0] == 0 ? 1536 : c[1:0] == 1 ? 1544 : 2048) << c[3:2]);
        end
        rd(8'h47, 8'h6F, "cfg_rd");
        i_cmd_host_model.wait_clk(1000);
        chk("cfg", {irq, chop_per == 7, sig, src, e1}, 5'b01100);
        en = 4'b0101;
        cmd(CMD_ACTIVATE);
        chk("act", act, 4'b0101);
        fsync_pulse();
        chk("txv1", txv, 4'b0000);
        fsync_pulse();
        chk("txv2", txv, 4'b0101);
        en = 4'h0;
        cmd(CMD_HW_RESET);
        chk("act_rst", act, 4'h0);
        chk("ires", ires_n, 1);
        i_cmd_host_model.wait_clk(1000);
        defaults();
        en = 4'hF;
        wr(8'h40, 8'h11);
        chk("txall", txs, {4{7'h11}});
        i_cmd_host_model.xfer(16'h4011, 16, r);
        chk("txslot16", txs, SLOT_RST);
        chk("ires16", ires_n, 2);
        wr(8'h46, 8'h05);
        chk("freq2x", {freq, resv}, {16'd3088, 1'b0});
        nrst_i = 1'b0;
        i_cmd_host_model.wait_clk(2);
        nrst_i = 1'b1;
        i_cmd_host_model.wait_clk(1000);
        defaults();
        chk("ires_pin", ires_n, 2);
        give_verdict();
    end
endmodule

// File: sim/cmd_host_model.sv
// Purpose: host processor model on the serial command link
// Assumes: data clock idles high, phases of 5 system cycles
// Notes:   read bits are sampled just before each falling data clock edge
`timescale 1ns/10ps
module cmd_host_model (
    input  wire logic clk_i,
    input  wire logic dev_dio_i,
    output logic      sel_n_o,
    output logic      dclk_o,
    output logic      dio_o
);
    initial begin
        sel_n_o = 1'b1;
        dclk_o  = 1'b1;
        dio_o   = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // one unit per select-low period; 16 bits makes the reset frame
    task automatic xfer(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        sel_n_o = 1'b0;
        wait_clk(8);
        for (int i = nbits - 1; i >= 0; i--) begin
            rx = {rx[6:0], dev_dio_i};
            dclk_o = 1'b0;
            dio_o = tx[i];
            wait_clk(5);
            dclk_o = 1'b1;
            wait_clk(5);
        end
        sel_n_o = 1'b1;
        // released line must not keep showing the last bit
        dio_o = ~dio_o;
        wait_clk(8);
    endtask
endmodule
